// ==== logic/filter_coeff_lvds_delay_regs.sv ====
// Register bank for channel 2 to 8 filter taps, link edge delays and reference mode.
// Assumes an Avalon-MM master on the same clock, byte addresses, one word per register.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "regbank_params.svh"

module filter_coeff_lvds_delay_regs #(
	parameter int NUM_CHAN = 7,
	parameter int TAPS = 12
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Avalon-MM slave.
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Filter tap fetch, channel 0 is channel 2.
	input wire logic [2:0] tap_chan,
	input wire logic [3:0] tap_index,
	output logic [11:0] tap_value,
	output logic [6:0] custom_tap_select,
	// Output link edge delays.
	output logic edge_delay_enable,
	output logic [1:0] data_rise_shift,
	output logic [2:0] bitclk_rise_shift,
	output logic [1:0] data_fall_shift,
	output logic [2:0] bitclk_fall_shift,
	// Reference and map control.
	output logic external_reference_select,
	output logic upper_map_access_enable
);
	// ----------------------------------------------------------------
	// Sizing checks.
	// ----------------------------------------------------------------
	if (NUM_CHAN != `NUM_CH || TAPS != `TAPS_PER_CH) begin : g_chk
		$error("filter_coeff_lvds_delay_regs: sizes must match the register map");
	end

	localparam int DEPTH = NUM_CHAN * TAPS;
	localparam logic [6:0] TAPS7 = 7'(TAPS);

	regbank_pkg::regs_t st_q, st_d;

	logic [7:0] idx;
	logic [7:0] entry;
	logic in_coeff;
	logic hit_ctrl;
	logic hit_delay;
	logic hit_ref;
	logic [NUM_CHAN-1:0] bank_hit;
	logic bank_sel;
	logic mem_wr;
	logic [11:0] mem_mask;
	logic [11:0] mem_a_data;
	logic [6:0] tap_addr;

	// ----------------------------------------------------------------
	// Address decode.
	// ----------------------------------------------------------------
	// The two low address bits pick a byte inside a word and are ignored.
	assign idx = address[9:2];
	assign in_coeff = idx >= `IDX_CH2_BANK && idx <= `IDX_COEFF_LAST;
	assign entry = idx - `IDX_CH2_BANK;
	assign hit_ctrl = idx == `IDX_UPPER_CTRL;
	assign hit_delay = idx == `IDX_EDGE_DELAY;
	// The reference word is invisible, as if unmapped, while the upper map is locked.
	assign hit_ref = idx == `IDX_REF_MODE && st_q.high_en;

	// Each bank is twelve consecutive words starting at its own base.
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_bank
		localparam logic [7:0] LO = 8'(c * TAPS);
		localparam logic [7:0] HI = 8'((c + 1) * TAPS);
		assign bank_hit[c] = in_coeff && entry >= LO && entry < HI;
	end

	assign bank_sel = |(bank_hit & st_q.sel);

	// ----------------------------------------------------------------
	// Tap store.
	// ----------------------------------------------------------------
	// Lane 0 carries tap bits 7:0 and lane 1 tap bits 11:8.
	assign mem_wr = write && in_coeff;
	assign mem_mask = {{4{byteenable[1]}}, {8{byteenable[0]}}};
	assign tap_addr = 7'(tap_chan) * TAPS7 + 7'(tap_index);

	// Taps are stored whatever the select says, so enabling later needs no rewrite.
	coeff_mem #(
		.DEPTH(DEPTH),
		.WIDTH(`TAP_W),
		.AW(7)
	) u_mem (
		.clock(clock),
		.srst(srst),
		.wr_en(mem_wr),
		.wr_addr(entry[6:0]),
		.wr_mask(mem_mask),
		.wr_data(writedata[`FLD_TAP]),
		.a_addr(entry[6:0]),
		.a_data(mem_a_data),
		.b_addr(tap_addr),
		.b_data(tap_value)
	);

	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// Writes never wait, so a write is taken on the edge it is presented.
		if (write) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				if (bank_hit[c] && byteenable[1]) begin
					st_d.sel[c] = writedata[`BIT_SELECT];
				end
			end
			if (hit_ctrl && byteenable[0]) begin
				st_d.high_en = writedata[`BIT_UPPER_EN];
			end
			// Bits 14:10 are dropped; software keeps them zero anyway.
			if (hit_delay && byteenable[0]) begin
				st_d.delay[7:0] = writedata[7:0];
			end
			if (hit_delay && byteenable[1]) begin
				st_d.delay[`FLD_DATA_RISE] = writedata[`FLD_DATA_RISE];
				st_d.delay[`BIT_DELAY_EN] = writedata[`BIT_DELAY_EN];
			end
			// Only the select bit is kept; the rest of the word reads zero.
			if (hit_ref && byteenable[1]) begin
				st_d.ref_sel = writedata[`BIT_REF_SEL];
			end
		end
		// A read spends one cycle in the tap store and one in the read register.
		case (st_q.phase)
			regbank_pkg::RD_IDLE: begin
				if (read) begin
					st_d.phase = regbank_pkg::RD_FETCH;
				end
			end
			regbank_pkg::RD_FETCH: begin
				st_d.phase = regbank_pkg::RD_DONE;
				st_d.rdata = `RST_WORD;
				if (in_coeff) begin
					st_d.rdata[`BIT_SELECT] = bank_sel;
					st_d.rdata[`FLD_TAP] = mem_a_data;
				end else if (hit_ctrl) begin
					st_d.rdata[`BIT_UPPER_EN] = st_q.high_en;
				end else if (hit_delay) begin
					st_d.rdata = st_q.delay;
				end else if (hit_ref) begin
					st_d.rdata[`BIT_REF_SEL] = st_q.ref_sel;
				end
			end
			regbank_pkg::RD_DONE: begin
				st_d.phase = regbank_pkg::RD_IDLE;
			end
			default: begin
				st_d.phase = regbank_pkg::RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	assign waitrequest = read && st_q.phase != regbank_pkg::RD_DONE;
	assign readdata = {16'h0000, st_q.rdata};
	assign custom_tap_select = st_q.sel;
	assign external_reference_select = st_q.ref_sel;
	assign upper_map_access_enable = st_q.high_en;

	edge_delay_gate u_gate (
		.clock(clock),
		.srst(srst),
		.delay_word(st_q.delay),
		.edge_delay_enable(edge_delay_enable),
		.data_rise_shift(data_rise_shift),
		.bitclk_rise_shift(bitclk_rise_shift),
		.data_fall_shift(data_fall_shift),
		.bitclk_fall_shift(bitclk_fall_shift)
	);

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	write_no_wait_a: assert property (write |-> !waitrequest)
		else $error("write was stalled");

	read_two_waits_a: assert property (
		(read && st_q.phase == regbank_pkg::RD_IDLE) |-> waitrequest ##1 waitrequest ##1 !waitrequest)
		else $error("read answer not on third cycle");

	reset_clears_a: assert property (disable iff (1'b0) srst |=> (custom_tap_select == '0 &&
		!external_reference_select && !upper_map_access_enable && readdata == '0 &&
		!edge_delay_enable && !waitrequest))
		else $error("state not zero after reset");

	tap_select_write_a: assert property (
		(write && bank_hit[0] && byteenable[1]) |=> custom_tap_select[0] == $past(writedata[15]))
		else $error("channel 2 select not written");

	ch8_bank_decode_a: assert property (
		(in_coeff && idx >= `IDX_CH8_BANK) |-> bank_hit == 7'h40)
		else $error("channel 8 bank decode wrong");

	ref_locked_a: assert property (
		(write && idx == `IDX_REF_MODE && !upper_map_access_enable) |=>
		$stable(external_reference_select))
		else $error("reference written while locked");

	ref_select_a: assert property (
		(write && idx == `IDX_REF_MODE && upper_map_access_enable && byteenable[1]) |=>
		external_reference_select == $past(writedata[15]))
		else $error("reference select not written");

	delay_gated_a: assert property (
		!edge_delay_enable |=> (data_rise_shift == '0 && bitclk_rise_shift == '0 &&
		data_fall_shift == '0 && bitclk_fall_shift == '0))
		else $error("delay applied while disabled");

	delay_fields_a: assert property (
		edge_delay_enable |=> (data_rise_shift == $past(st_q.delay[9:8]) &&
		bitclk_rise_shift == $past(st_q.delay[7:5]) && data_fall_shift == $past(st_q.delay[4:3]) &&
		bitclk_fall_shift == $past(st_q.delay[2:0])))
		else $error("delay fields misplaced");

	tap_pad_zero_a: assert property (
		(read && !waitrequest && in_coeff) |-> readdata[14:12] == 3'h0 && readdata[31:16] == '0)
		else $error("tap readback padding not zero");

	// Each twelve-word window must light exactly one bank bit, and none outside the map.
	ch2_bank_decode_a: assert property (
		(idx >= `IDX_CH2_BANK && idx < `IDX_CH3_BANK) |-> bank_hit == 7'h01)
		else $error("channel 2 bank decode wrong");

	ch3_bank_decode_a: assert property (
		(idx >= `IDX_CH3_BANK && idx < `IDX_CH4_BANK) |-> bank_hit == 7'h02)
		else $error("channel 3 bank decode wrong");

	ch4_bank_decode_a: assert property (
		(idx >= `IDX_CH4_BANK && idx < `IDX_CH5_BANK) |-> bank_hit == 7'h04)
		else $error("channel 4 bank decode wrong");

	ch5_bank_decode_a: assert property (
		(idx >= `IDX_CH5_BANK && idx < `IDX_CH6_BANK) |-> bank_hit == 7'h08)
		else $error("channel 5 bank decode wrong");

	ch6_bank_decode_a: assert property (
		(idx >= `IDX_CH6_BANK && idx < `IDX_CH7_BANK) |-> bank_hit == 7'h10)
		else $error("channel 6 bank decode wrong");

	ch7_bank_decode_a: assert property (
		(idx >= `IDX_CH7_BANK && idx < `IDX_CH8_BANK) |-> bank_hit == 7'h20)
		else $error("channel 7 bank decode wrong");

	outside_no_bank_a: assert property (
		(idx < `IDX_CH2_BANK || idx > `IDX_COEFF_LAST) |-> bank_hit == 7'h00)
		else $error("bank decoded outside the tap map");

	select_readback_a: assert property (
		(st_q.phase == regbank_pkg::RD_FETCH && in_coeff) |=>
		readdata[`BIT_SELECT] == |($past(bank_hit) & custom_tap_select))
		else $error("tap select readback wrong");

	select_kept_a: assert property (!write |=> $stable(custom_tap_select))
		else $error("tap select changed without a write");

	ref_locked_read_a: assert property (
		(st_q.phase == regbank_pkg::RD_FETCH && idx == `IDX_REF_MODE && !upper_map_access_enable)
		|=> readdata == 32'h00000000)
		else $error("locked reference word was readable");

	ref_pad_zero_a: assert property (
		(st_q.phase == regbank_pkg::RD_FETCH && hit_ref) |=>
		readdata[15:0] == {external_reference_select, 15'h0000})
		else $error("reference readback wrong");

	delay_pad_zero_a: assert property (
		(st_q.phase == regbank_pkg::RD_FETCH && hit_delay) |=>
		readdata[15:10] == {edge_delay_enable, 5'h00})
		else $error("delay readback wrong");

	unmapped_read_zero_a: assert property (
		(st_q.phase == regbank_pkg::RD_FETCH && idx > `IDX_COEFF_LAST &&
		idx != `IDX_EDGE_DELAY && idx != `IDX_REF_MODE) |=> readdata == 32'h00000000)
		else $error("unmapped word read nonzero");

	upper_enable_write_a: assert property (
		(write && hit_ctrl && byteenable[0]) |=>
		upper_map_access_enable == $past(writedata[`BIT_UPPER_EN]))
		else $error("upper map enable not written");

	delay_enable_write_a: assert property (
		(write && hit_delay && byteenable[1]) |=>
		edge_delay_enable == $past(writedata[`BIT_DELAY_EN]))
		else $error("delay enable not written");

	// The fetch port must keep showing a tap until that tap is written or reset.
	tap_hold_a: assert property (
		(!$past(write) && !$past(srst) && $stable(tap_addr)) |=> $stable(tap_value))
		else $error("stored tap changed without a write");

	readdata_holds_a: assert property (
		st_q.phase != regbank_pkg::RD_FETCH |=> $stable(readdata))
		else $error("read data moved outside a read");

	cover_tap_write_c: cover property (write && in_coeff && byteenable[1:0] == 2'h3);
	cover_ref_write_c: cover property (write && hit_ref);
	cover_read_done_c: cover property (read && !waitrequest && in_coeff);
	cover_delay_on_c: cover property ($rose(edge_delay_enable));
endmodule // filter_coeff_lvds_delay_regs

`default_nettype wire

// ==== logic/regbank_params.svh ====
// Offsets, field positions, reset values and sizes of the filter tap and link delay register bank.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef REGBANK_PARAMS_SVH
`define REGBANK_PARAMS_SVH

// ----------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------
`define IDX_UPPER_CTRL 8'h01
`define IDX_CH2_BANK 8'h66
`define IDX_CH3_BANK 8'h72
`define IDX_CH4_BANK 8'h7e
`define IDX_CH5_BANK 8'h8a
`define IDX_CH6_BANK 8'h96
`define IDX_CH7_BANK 8'ha2
`define IDX_CH8_BANK 8'hae
`define IDX_COEFF_LAST 8'hb9
`define IDX_EDGE_DELAY 8'hbe
`define IDX_REF_MODE 8'hf0

// ----------------------------------------------------------------
// Field positions and sizes.
// ----------------------------------------------------------------
`define BIT_SELECT 15
`define BIT_UPPER_EN 4
`define BIT_REF_SEL 15
`define BIT_DELAY_EN 15
`define NUM_CH 7
`define TAPS_PER_CH 12
`define TAP_W 12
`define FLD_TAP 11:0
`define FLD_DATA_RISE 9:8
`define FLD_CLK_RISE 7:5
`define FLD_DATA_FALL 4:3
`define FLD_CLK_FALL 2:0
`define RST_WORD 16'h0000

`endif

// ==== logic/regbank_pkg.sv ====
// Types shared by the register bank modules.
// Assumes regbank_params.svh is on the include path.
`default_nettype none
`include "regbank_params.svh"

package regbank_pkg;

	typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_DONE} rd_phase_t;

	typedef struct packed {
		rd_phase_t phase;
		logic [15:0] rdata;
		logic high_en;
		logic ref_sel;
		logic [15:0] delay;
		logic [`NUM_CH-1:0] sel;
	} regs_t;

	typedef struct packed {
		logic [1:0] data_rise;
		logic [2:0] clk_rise;
		logic [1:0] data_fall;
		logic [2:0] clk_fall;
	} shifts_t;

endpackage

`default_nettype wire

// ==== logic/coeff_mem.sv ====
// Tap store with one masked write port and two registered read ports.
// Assumes one clock and a synchronous reset that clears every entry.
`timescale 1ns/1ps
`default_nettype none

module coeff_mem #(
	parameter int DEPTH = 84,
	parameter int WIDTH = 12,
	parameter int AW = 7
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Write port.
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_mask,
	input wire logic [WIDTH-1:0] wr_data,
	// Read ports.
	input wire logic [AW-1:0] a_addr,
	output logic [WIDTH-1:0] a_data,
	input wire logic [AW-1:0] b_addr,
	output logic [WIDTH-1:0] b_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("coeff_mem: DEPTH does not fit AW");
	end

	// Out-of-range reads give zero rather than an undefined word.
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			a_data <= '0;
			b_data <= '0;
		end else begin
			if (wr_en && int'(wr_addr) < DEPTH) begin
				mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
			end
			a_data <= (int'(a_addr) < DEPTH) ? mem[a_addr] : '0;
			b_data <= (int'(b_addr) < DEPTH) ? mem[b_addr] : '0;
		end
	end
endmodule // coeff_mem

`default_nettype wire

// ==== logic/edge_delay_gate.sv ====
// Gates the programmed link edge shifts with their enable and registers the result.
// Assumes the delay word comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "regbank_params.svh"

module edge_delay_gate (
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Stored delay word.
	input wire logic [15:0] delay_word,
	// Effective shifts.
	output logic edge_delay_enable,
	output logic [1:0] data_rise_shift,
	output logic [2:0] bitclk_rise_shift,
	output logic [1:0] data_fall_shift,
	output logic [2:0] bitclk_fall_shift
);
	regbank_pkg::shifts_t sh_q, sh_d;

	always_comb begin
		sh_d = '0;
		if (delay_word[`BIT_DELAY_EN]) begin
			sh_d.data_rise = delay_word[`FLD_DATA_RISE];
			sh_d.clk_rise = delay_word[`FLD_CLK_RISE];
			sh_d.data_fall = delay_word[`FLD_DATA_FALL];
			sh_d.clk_fall = delay_word[`FLD_CLK_FALL];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sh_q <= '0;
		end else begin
			sh_q <= sh_d;
		end
	end

	assign edge_delay_enable = delay_word[`BIT_DELAY_EN];
	assign data_rise_shift = sh_q.data_rise;
	assign bitclk_rise_shift = sh_q.clk_rise;
	assign data_fall_shift = sh_q.data_fall;
	assign bitclk_fall_shift = sh_q.clk_fall;
endmodule // edge_delay_gate

`default_nettype wire

// ==== logic/dummy_unused_never.sv ====
`default_nettype none
`default_nettype wire

// ==== test/tb_filter_coeff_lvds_delay_regs.sv ====
// Self-checking bench for the filter tap, link edge delay and reference mode register bank.
// Assumes the files under logic/ are compiled first and regbank_params.svh is on the path.
`timescale 1ns/1ps
`default_nettype none

module tb_filter_coeff_lvds_delay_regs;
	typedef struct packed {
		logic [7:0] widx;
		logic [15:0] wdata;
		logic [3:0] be;
		logic [7:0] ridx;
		logic [15:0] rexp;
	} row_t;

	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [9:0] address = 10'h000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [2:0] tap_chan = 3'h0;
	logic [3:0] tap_index = 4'h0;
	logic [11:0] tap_value;
	logic [6:0] custom_tap_select;
	logic edge_delay_enable;
	logic [1:0] data_rise_shift;
	logic [2:0] bitclk_rise_shift;
	logic [1:0] data_fall_shift;
	logic [2:0] bitclk_fall_shift;
	logic external_reference_select;
	logic upper_map_access_enable;
	logic [10:0] shifts;
	logic [31:0] rd;
	int fails = 0;
	int total_checks = 0;

	// Rows run in order: the custom select of a bank follows the last write to it with lane 1 enabled.
	row_t rows [0:15] = '{
		'{8'h66, 16'h8abc, 4'h3, 8'h66, 16'h8abc},
		'{8'h71, 16'h0123, 4'h3, 8'h66, 16'h0abc},
		'{8'h72, 16'h8001, 4'h3, 8'h7d, 16'h8000},
		'{8'h89, 16'h8555, 4'h3, 8'h89, 16'h8555},
		'{8'h8a, 16'h8aaa, 4'h3, 8'h8a, 16'h8aaa},
		'{8'h95, 16'h0777, 4'h3, 8'h8a, 16'h0aaa},
		'{8'ha1, 16'h8321, 4'h3, 8'ha1, 16'h8321},
		'{8'had, 16'h8fed, 4'h3, 8'ha2, 16'h8000},
		'{8'hb9, 16'h8042, 4'h3, 8'hae, 16'h8000},
		'{8'h7e, 16'h0fff, 4'h1, 8'h7e, 16'h80ff},
		'{8'h7e, 16'h8a00, 4'h2, 8'h7e, 16'h8aff},
		'{8'hbe, 16'h8176, 4'h3, 8'hbe, 16'h8176},
		'{8'hc0, 16'h1234, 4'h3, 8'hc0, 16'h0000},
		'{8'hf0, 16'h8000, 4'h3, 8'hf0, 16'h0000},
		'{8'h01, 16'h0010, 4'h3, 8'h01, 16'h0010},
		'{8'hf0, 16'h8000, 4'h3, 8'hf0, 16'h8000}
	};

	assign shifts = {edge_delay_enable, data_rise_shift, bitclk_rise_shift,
		data_fall_shift, bitclk_fall_shift};

	filter_coeff_lvds_delay_regs #(.NUM_CHAN(7), .TAPS(12)) uut (
		.clock(clock),
		.srst(srst),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.tap_chan(tap_chan),
		.tap_index(tap_index),
		.tap_value(tap_value),
		.custom_tap_select(custom_tap_select),
		.edge_delay_enable(edge_delay_enable),
		.data_rise_shift(data_rise_shift),
		.bitclk_rise_shift(bitclk_rise_shift),
		.data_fall_shift(data_fall_shift),
		.bitclk_fall_shift(bitclk_fall_shift),
		.external_reference_select(external_reference_select),
		.upper_map_access_enable(upper_map_access_enable)
	);

	always #2.5 clock = ~clock;

	// ----------------------------------------------------------------
	// Comparison and bus tasks.
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Waitrequest and read data are taken at the rising edge itself; the design's
	// updates from that edge land later in the time step, so the edge's values are seen.
	task automatic bus_write(input logic [7:0] idx, input logic [15:0] data, input logic [3:0] be);
		address <= {idx, 2'b00};
		writedata <= {16'h0000, data};
		byteenable <= be;
		write <= 1'b1;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge clock);
	endtask

	task automatic bus_read(input logic [7:0] idx, output logic [31:0] data);
		address <= {idx, 2'b00};
		read <= 1'b1;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		data = readdata;
		read <= 1'b0;
		@(posedge clock);
	endtask

	task automatic tap_check(input logic [2:0] ch, input logic [3:0] idx, input logic [11:0] exp);
		tap_chan <= ch;
		tap_index <= idx;
		@(posedge clock);
		@(negedge clock);
		check({20'h00000, tap_value}, {20'h00000, exp});
		@(posedge clock);
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		@(negedge clock);
		check({21'h000000, shifts}, 32'h00000000);
		@(posedge clock);
		for (int i = 0; i < 16; i++) begin
			bus_write(rows[i].widx, rows[i].wdata, rows[i].be);
			bus_read(rows[i].ridx, rd);
			check(rd, {16'h0000, rows[i].rexp});
		end
		@(negedge clock);
		check({25'h0000000, custom_tap_select}, 32'h00000076);
		check({21'h000000, shifts}, 32'h00000576);
		check({30'h00000000, external_reference_select, upper_map_access_enable},
			32'h00000003);
		@(posedge clock);
		tap_check(3'h0, 4'h0, 12'habc);
		tap_check(3'h0, 4'hb, 12'h123);
		tap_check(3'h5, 4'hb, 12'hfed);
		tap_check(3'h6, 4'hb, 12'h042);
		tap_check(3'h2, 4'h0, 12'haff);
		// A later select write must bring back the taps kept meanwhile.
		bus_write(8'h71, 16'h8123, 4'h3);
		bus_read(8'h66, rd);
		check(rd, 32'h00008abc);
		bus_write(8'hbe, 16'h0176, 4'h3);
		@(negedge clock);
		check({21'h000000, shifts}, 32'h00000000);
		@(posedge clock);
		// Reset in mid-run clears every register and every tap.
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		@(negedge clock);
		check({25'h0000000, custom_tap_select}, 32'h00000000);
		check({30'h00000000, external_reference_select, upper_map_access_enable},
			32'h00000000);
		@(posedge clock);
		bus_read(8'h66, rd);
		check(rd, 32'h00000000);
		bus_read(8'hbe, rd);
		check(rd, 32'h00000000);
		tap_check(3'h5, 4'hb, 12'h000);
		bus_write(8'h01, 16'h0010, 4'h3);
		bus_read(8'hf0, rd);
		check(rd, 32'h00000000);
		tally_and_finish();
	end

	initial begin
		repeat (4000) @(posedge clock);
		fails++;
		tally_and_finish();
	end
endmodule // tb_filter_coeff_lvds_delay_regs

`default_nettype wire
